// >>> shared/irq_unit_pkg.sv
// Register map, field positions and constants of the single-vector interrupt unit
package irq_unit_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TIMER_EN = 10'h00a;
  localparam logic [IDX_W-1:0] IDX_TIMER_FLAGS = 10'h00b;
  localparam logic [IDX_W-1:0] IDX_EXT_EN = 10'h00c;
  localparam logic [IDX_W-1:0] IDX_EXT_FLAGS = 10'h00d;
  localparam logic [IDX_W-1:0] IDX_TOUCH_EN = 10'h00e;
  localparam logic [IDX_W-1:0] IDX_TOUCH_FLAGS = 10'h00f;
  localparam logic [IDX_W-1:0] IDX_BUS_EN = 10'h01e;
  localparam logic [IDX_W-1:0] IDX_BUS_FLAGS = 10'h01f;
  localparam logic [IDX_W-1:0] IDX_TRIGGER_SEL = 10'h20c;
  localparam logic [IDX_W-1:0] IDX_PIN_DET_SEL = 10'h20e;
  localparam logic [IDX_W-1:0] IDX_SERVICE_STATE = 10'h040;
  localparam logic [IDX_W-1:0] IDX_EVENT_STATUS = 10'h041;
  localparam logic [IDX_W-1:0] IDX_EVENT_MASK = 10'h042;
  localparam logic [IDX_W-1:0] IDX_WATCHDOG_CLEAR = 10'h043;
  // Field positions
  localparam int EXT_A_PIN_SEL_BIT = 0;
  localparam int EXT_B_PIN_SEL_BIT = 1;
  localparam int EXT_A_DETECTOR_SEL_BIT = 3;
  localparam int EV_REQUEST_BIT = 0;
  localparam int EV_WDOG_BIT = 1;
  localparam int EV_WAKE_BIT = 2;
  // Reset values and masks
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [3:0] TOUCH_IMPL_MASK = 4'he;
  localparam logic [3:0] PIN_DET_IMPL_MASK = 4'hb;
  localparam logic [3:0] WDOG_ARM_VALUE = 4'hf;
  localparam logic [2:0] EVENT_RESET = 3'h0;
  localparam logic [11:0] SERVICE_VECTOR = 12'h001;
  // Trigger codes
  localparam logic [1:0] TRIG_LOW_LEVEL = 2'h0;
  localparam logic [1:0] TRIG_FALLING = 2'h1;
  localparam logic [1:0] TRIG_RISING = 2'h2;
  localparam logic [1:0] TRIG_BOTH = 2'h3;
  // Pin slots of the input filter
  localparam int PIN_COUNT = 5;
  localparam int PIN_A_PRIMARY = 0;
  localparam int PIN_A_ALTERNATE = 1;
  localparam int PIN_A_COMPARATOR = 2;
  localparam int PIN_B_PRIMARY = 3;
  localparam int PIN_B_ALTERNATE = 4;
endpackage : irq_unit_pkg

// >>> rtl/single_vector_interrupt_unit.sv
// Single-vector interrupt unit with Avalon-MM register slave
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Every accepted request goes to one fixed vector, no priority.
// - A new request waits while a service routine runs, taken after return.
// - Request to the processor only when some enable and its flag are both one.
// - Main flag registers: writing zero clears a flag, writing one does nothing.
// - Timer overflow sets its flag, which stays until software clears it.
// - First external trigger: low level, falling, rising or both edges.
// - Second external trigger: same four choices.
// - Timer group bits: tick one, timer one, timer two, tick two.
// - Extended group bits: external a, external b, converter, timer three.
// - Touch group: bit 0 unused, scan done, overcharge, duty overflow.
// - Serial group: bus event, start, stop, first byte sent.
// - Each external input picks primary or alternate pin by one bit.
// - First input may use a comparator, only on its alternate pin.
// - Two periodic ticks are separate sources with own flags.
// - Trigger, enable and flag registers reset to zero.
// - All-ones to timer flags arms, then a watchdog clear write completes.
// - Sleep wakes on any request, stop only on external requests.
module single_vector_interrupt_unit (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [irq_unit_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [irq_unit_pkg::DATA_W-1:0] writedata,
  output logic [irq_unit_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic tick_one,
  input wire logic tick_two,
  input wire logic timer_one_ovf,
  input wire logic timer_two_ovf,
  input wire logic timer_three_ovf,
  input wire logic converter_done,
  input wire logic touch_scan_done,
  input wire logic touch_overcharge,
  input wire logic touch_duty_ovf,
  input wire logic bus_event,
  input wire logic bus_start,
  input wire logic bus_stop,
  input wire logic bus_first_byte,
  input wire logic ext_a_primary_pin,
  input wire logic ext_a_alternate_pin,
  input wire logic ext_a_comparator,
  input wire logic ext_b_primary_pin,
  input wire logic ext_b_alternate_pin,
  input wire logic cpu_ack,
  input wire logic cpu_return,
  input wire logic sleep_mode,
  input wire logic stop_mode,
  output logic cpu_irq,
  output logic [11:0] vector_addr,
  output logic wake,
  output logic watchdog_clear,
  output logic comparator_enable,
  output logic irq
);
  import irq_unit_pkg::*;

  typedef struct packed {
    logic ack;
    logic waitreq;
    logic [DATA_W-1:0] rdata;
    logic [3:0] timer_en;
    logic [3:0] timer_flags;
    logic [3:0] ext_en;
    logic [3:0] ext_flags;
    logic [3:0] touch_en;
    logic [3:0] touch_flags;
    logic [3:0] bus_en;
    logic [3:0] bus_flags;
    logic [3:0] trigger_sel;
    logic [3:0] pin_det_sel;
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic [PIN_COUNT-1:0] sync3;
    logic [PIN_COUNT-1:0] level;
    logic in_service;
    logic cpu_irq;
    logic [11:0] vector;
    logic wdog_arm;
    logic wdog_clear;
    logic wake;
    logic cmp_en;
    logic [2:0] ev_status;
    logic [2:0] ev_mask;
    logic irq;
  } state_t;

  state_t state_reg;
  state_t state_next;

  localparam state_t STATE_RESET = '{
    ack: 1'b0, waitreq: 1'b1, rdata: 32'h0000_0000,
    timer_en: NIBBLE_RESET, timer_flags: NIBBLE_RESET,
    ext_en: NIBBLE_RESET, ext_flags: NIBBLE_RESET,
    touch_en: NIBBLE_RESET, touch_flags: NIBBLE_RESET,
    bus_en: NIBBLE_RESET, bus_flags: NIBBLE_RESET,
    trigger_sel: NIBBLE_RESET, pin_det_sel: NIBBLE_RESET,
    sync1: 5'h1f, sync2: 5'h1f, sync3: 5'h1f, level: 5'h1f,
    in_service: 1'b0, cpu_irq: 1'b0, vector: SERVICE_VECTOR,
    wdog_arm: 1'b0, wdog_clear: 1'b0, wake: 1'b0, cmp_en: 1'b0,
    ev_status: EVENT_RESET, ev_mask: EVENT_RESET, irq: 1'b0
  };

  function automatic logic trig_hit(input logic [1:0] code, input logic old_l,
                                    input logic new_l);
    logic hit;
    hit = 1'b0;
    unique case (code)
      TRIG_LOW_LEVEL: hit = ~new_l;
      TRIG_FALLING: hit = old_l & ~new_l;
      TRIG_RISING: hit = ~old_l & new_l;
      TRIG_BOTH: hit = old_l ^ new_l;
    endcase
    return hit;
  endfunction : trig_hit

  logic [IDX_W-1:0] idx;
  logic wr_hit;
  logic [3:0] wd;
  logic a_old;
  logic a_new;
  logic b_old;
  logic b_new;
  logic a_hit;
  logic b_hit;
  logic pend_q;
  logic pend_ext_q;
  logic [3:0] timer_set;
  logic [3:0] ext_set;

  assign idx = address[ADDR_W-1:2];
  assign wr_hit = write & state_reg.ack & byteenable[0];
  assign wd = writedata[3:0];
  // Sources in register bit order
  assign timer_set = {tick_two, timer_two_ovf, timer_one_ovf, tick_one};
  assign pend_q = |{state_reg.timer_en & state_reg.timer_flags,
                    state_reg.ext_en & state_reg.ext_flags,
                    state_reg.touch_en & state_reg.touch_flags,
                    state_reg.bus_en & state_reg.bus_flags};
  assign pend_ext_q = |(state_reg.ext_en[1:0] & state_reg.ext_flags[1:0]);

  always_comb begin
    logic pend_n;
    logic pend_ext_n;
    logic a_sel_cmp;
    pend_n = 1'b0;
    pend_ext_n = 1'b0;
    a_sel_cmp = 1'b0;
    a_old = 1'b0;
    a_new = 1'b0;
    b_old = 1'b0;
    b_new = 1'b0;
    state_next = state_reg;
    // Register answer: one wait cycle, then waitrequest low for one cycle
    state_next.ack = (read | write) & ~state_reg.ack;
    state_next.waitreq = ~state_next.ack;
    // Input filter: a level counts once the second and third stages agree
    state_next.sync1 = {ext_b_alternate_pin, ext_b_primary_pin, ext_a_comparator,
                        ext_a_alternate_pin, ext_a_primary_pin};
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (state_reg.sync2[i] == state_reg.sync3[i]) begin
        state_next.level[i] = state_reg.sync3[i];
      end
    end
    // Pin routing; old and new level come from the same selected pin, so switching the selector gives no edge
    a_sel_cmp = state_reg.pin_det_sel[EXT_A_DETECTOR_SEL_BIT]
                & state_reg.pin_det_sel[EXT_A_PIN_SEL_BIT];
    if (!state_reg.pin_det_sel[EXT_A_PIN_SEL_BIT]) begin
      a_old = state_reg.level[PIN_A_PRIMARY];
      a_new = state_next.level[PIN_A_PRIMARY];
    end else if (a_sel_cmp) begin
      a_old = state_reg.level[PIN_A_COMPARATOR];
      a_new = state_next.level[PIN_A_COMPARATOR];
    end else begin
      a_old = state_reg.level[PIN_A_ALTERNATE];
      a_new = state_next.level[PIN_A_ALTERNATE];
    end
    if (!state_reg.pin_det_sel[EXT_B_PIN_SEL_BIT]) begin
      b_old = state_reg.level[PIN_B_PRIMARY];
      b_new = state_next.level[PIN_B_PRIMARY];
    end else begin
      b_old = state_reg.level[PIN_B_ALTERNATE];
      b_new = state_next.level[PIN_B_ALTERNATE];
    end
    state_next.cmp_en = a_sel_cmp;
    a_hit = trig_hit(state_reg.trigger_sel[1:0], a_old, a_new);
    b_hit = trig_hit(state_reg.trigger_sel[3:2], b_old, b_new);
    ext_set = {timer_three_ovf, converter_done, b_hit, a_hit};
    // Writes take effect on the cycle that waitrequest is low
    if (wr_hit) begin
      unique case (idx)
        IDX_TIMER_EN: state_next.timer_en = wd;
        IDX_TIMER_FLAGS: state_next.timer_flags = state_reg.timer_flags & wd;
        IDX_EXT_EN: state_next.ext_en = wd;
        IDX_EXT_FLAGS: state_next.ext_flags = state_reg.ext_flags & wd;
        IDX_TOUCH_EN: state_next.touch_en = wd & TOUCH_IMPL_MASK;
        IDX_TOUCH_FLAGS: state_next.touch_flags = wd & TOUCH_IMPL_MASK;
        IDX_BUS_EN: state_next.bus_en = wd;
        IDX_BUS_FLAGS: state_next.bus_flags = wd;
        IDX_TRIGGER_SEL: state_next.trigger_sel = wd;
        IDX_PIN_DET_SEL: state_next.pin_det_sel = wd & PIN_DET_IMPL_MASK;
        IDX_EVENT_STATUS: state_next.ev_status = state_reg.ev_status & ~wd[2:0];
        IDX_EVENT_MASK: state_next.ev_mask = wd[2:0];
        default: ;
      endcase
    end
    // Hardware sets win over a same-cycle clear
    state_next.timer_flags = state_next.timer_flags | timer_set;
    state_next.ext_flags = state_next.ext_flags | ext_set;
    state_next.touch_flags = state_next.touch_flags
                             | {touch_duty_ovf, touch_overcharge, touch_scan_done, 1'b0};
    state_next.bus_flags = state_next.bus_flags
                           | {bus_first_byte, bus_stop, bus_start, bus_event};
    // Two-step watchdog clear; any other write to the timer flags disarms
    state_next.wdog_clear = 1'b0;
    if (wr_hit && idx == IDX_TIMER_FLAGS) begin
      state_next.wdog_arm = (wd == WDOG_ARM_VALUE);
    end else if (wr_hit && idx == IDX_WATCHDOG_CLEAR) begin
      state_next.wdog_arm = 1'b0;
      state_next.wdog_clear = state_reg.wdog_arm;
    end
    // Service hold: only cpu_return reopens the request line
    if (cpu_ack) begin
      state_next.in_service = 1'b1;
    end else if (cpu_return) begin
      state_next.in_service = 1'b0;
    end
    pend_n = |{state_next.timer_en & state_next.timer_flags,
               state_next.ext_en & state_next.ext_flags,
               state_next.touch_en & state_next.touch_flags,
               state_next.bus_en & state_next.bus_flags};
    pend_ext_n = |(state_next.ext_en[1:0] & state_next.ext_flags[1:0]);
    state_next.cpu_irq = pend_n & ~state_next.in_service;
    state_next.vector = SERVICE_VECTOR;
    state_next.wake = (sleep_mode & pend_n) | (stop_mode & pend_ext_n);
    // Own events, sticky until a one is written back
    if (state_next.cpu_irq & ~state_reg.cpu_irq) begin
      state_next.ev_status[EV_REQUEST_BIT] = 1'b1;
    end
    if (state_next.wdog_clear) begin
      state_next.ev_status[EV_WDOG_BIT] = 1'b1;
    end
    if (state_next.wake & ~state_reg.wake) begin
      state_next.ev_status[EV_WAKE_BIT] = 1'b1;
    end
    state_next.irq = |(state_next.ev_status & state_next.ev_mask);
    // Read data is latched as waitrequest drops and stands at the taking edge
    if (read & state_next.ack) begin
      state_next.rdata = '0;
      unique case (idx)
        IDX_TIMER_EN: state_next.rdata[3:0] = state_reg.timer_en;
        IDX_TIMER_FLAGS: state_next.rdata[3:0] = state_reg.timer_flags;
        IDX_EXT_EN: state_next.rdata[3:0] = state_reg.ext_en;
        IDX_EXT_FLAGS: state_next.rdata[3:0] = state_reg.ext_flags;
        IDX_TOUCH_EN: state_next.rdata[3:0] = state_reg.touch_en;
        IDX_TOUCH_FLAGS: state_next.rdata[3:0] = state_reg.touch_flags;
        IDX_BUS_EN: state_next.rdata[3:0] = state_reg.bus_en;
        IDX_BUS_FLAGS: state_next.rdata[3:0] = state_reg.bus_flags;
        IDX_TRIGGER_SEL: state_next.rdata[3:0] = state_reg.trigger_sel;
        IDX_PIN_DET_SEL: state_next.rdata[3:0] = state_reg.pin_det_sel;
        IDX_SERVICE_STATE: state_next.rdata[1:0] = {state_reg.cpu_irq,
                                                    state_reg.in_service};
        IDX_EVENT_STATUS: state_next.rdata[2:0] = state_reg.ev_status;
        IDX_EVENT_MASK: state_next.rdata[2:0] = state_reg.ev_mask;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign readdata = state_reg.rdata;
  assign waitrequest = state_reg.waitreq;
  assign cpu_irq = state_reg.cpu_irq;
  assign vector_addr = state_reg.vector;
  assign wake = state_reg.wake;
  assign watchdog_clear = state_reg.wdog_clear;
  assign comparator_enable = state_reg.cmp_en;
  assign irq = state_reg.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence seq_arm_write;
    wr_hit && idx == IDX_TIMER_FLAGS && wd == WDOG_ARM_VALUE;
  endsequence
  sequence seq_clear_write;
    wr_hit && idx == IDX_WATCHDOG_CLEAR;
  endsequence
  sequence seq_quiet_timer_flags;
    !(wr_hit && (idx == IDX_TIMER_FLAGS || idx == IDX_WATCHDOG_CLEAR));
  endsequence

  AST_FIXED_VECTOR: assert property (vector_addr == SERVICE_VECTOR)
    else $error("vector differs from the fixed entry");
  AST_HOLD_IN_SERVICE: assert property (cpu_ack |=> !cpu_irq throughout
    (!cpu_return [*2]))
    else $error("request raised during service");
  AST_REQUEST_CAUSE: assert property (cpu_irq |-> pend_q && !state_reg.in_service)
    else $error("request without enabled flag");
  AST_REQUEST_RAISE: assert property (pend_q && !state_reg.in_service && !cpu_ack
    && $stable(pend_q) |=> cpu_irq || cpu_return || !pend_q)
    else $error("pending source not signalled");
  AST_WRITE_ONE_NO_SET: assert property (wr_hit && idx == IDX_EXT_FLAGS
    && !state_reg.ext_flags[2] && !converter_done |=> !state_reg.ext_flags[2])
    else $error("software set a flag");
  AST_TIMER_FLAG_SET: assert property (timer_two_ovf |=> state_reg.timer_flags[2]
    [*2])
    else $error("overflow flag not held");
  AST_EXT_A_FALLING: assert property (state_reg.trigger_sel[1:0] == TRIG_FALLING
    && a_old && !a_new |=> state_reg.ext_flags[0])
    else $error("falling edge missed on first input");
  AST_EXT_B_RISING: assert property (state_reg.trigger_sel[3:2] == TRIG_RISING
    && !b_old && b_new |=> state_reg.ext_flags[1])
    else $error("rising edge missed on second input");
  AST_TOUCH_BIT0: assert property (state_reg.touch_flags[0] == 1'b0
    && state_reg.touch_en[0] == 1'b0)
    else $error("unused touch bit set");
  // Back-to-back bus writes leave two quiet cycles between the two steps
  AST_WDOG_TWO_STEP: assert property (seq_arm_write ##1 seq_quiet_timer_flags [*2]
    ##1 seq_clear_write |=> watchdog_clear)
    else $error("watchdog clear not completed");
  AST_WDOG_NEEDS_ARM: assert property (seq_clear_write and !state_reg.wdog_arm
    |=> !watchdog_clear)
    else $error("watchdog clear without arm");
  AST_STOP_WAKE: assert property (stop_mode && !sleep_mode
    && !(|(state_next.ext_en[1:0] & state_next.ext_flags[1:0])) |=> !wake)
    else $error("stop released by internal source");
  AST_SYNC_DELAY: assert property ($changed(state_reg.level[PIN_B_PRIMARY])
    |-> $past(state_reg.sync2[PIN_B_PRIMARY]) == $past(state_reg.sync3[PIN_B_PRIMARY]))
    else $error("level changed before filter agreed");
  AST_TICK_ONE_FLAG: assert property (tick_one
    |=> state_reg.timer_flags[0])
    else $error("first tick flag not set");
  AST_TICK_TWO_FLAG: assert property (tick_two
    |=> state_reg.timer_flags[3])
    else $error("second tick flag not set");
  AST_TIMER_ONE_FLAG: assert property (timer_one_ovf
    |=> state_reg.timer_flags[1])
    else $error("timer one flag not set");
  AST_CONVERTER_FLAG: assert property (converter_done
    |=> state_reg.ext_flags[2])
    else $error("converter flag not set");
  AST_BUS_START_FLAG: assert property (bus_start
    |=> state_reg.bus_flags[1])
    else $error("bus start flag not set");
  AST_TOUCH_OVF_FLAG: assert property (touch_duty_ovf
    |=> state_reg.touch_flags[3])
    else $error("duty overflow flag not set");
  AST_CMP_ONLY_ALT: assert property (comparator_enable
    |-> $past(state_reg.pin_det_sel[EXT_A_PIN_SEL_BIT]))
    else $error("comparator used on primary pin");
  AST_BUS_ONE_ACK: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
endmodule : single_vector_interrupt_unit

`default_nettype wire

// >>> testbench/cpu_core_model.sv
// Behavioural CPU core that takes the single vector and runs a service routine
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cpu_irq,
  input wire logic [11:0] vector_addr,
  input wire logic auto_en,
  input wire logic [7:0] service_cycles,
  output logic cpu_ack,
  output logic cpu_return,
  output logic [11:0] fetched_vector,
  output logic busy
);
  logic [7:0] cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_ack <= 1'h0;
      cpu_return <= 1'h0;
      fetched_vector <= 12'h0;
      busy <= 1'h0;
      cnt <= 8'h0;
    end else begin
      cpu_ack <= 1'h0;
      cpu_return <= 1'h0;
      if (!busy && auto_en && cpu_irq) begin
        // Vector is taken as offered, so a wrong one shows up
        cpu_ack <= 1'h1;
        fetched_vector <= vector_addr;
        busy <= 1'h1;
        cnt <= service_cycles;
      end else if (busy && cnt != 8'h0) begin
        cnt <= cnt - 8'h1;
      end else if (busy) begin
        // Bench clears serviced flags during the routine
        cpu_return <= 1'h1;
        busy <= 1'h0;
      end
    end
  end
endmodule : cpu_core_model
`default_nettype wire

// >>> testbench/single_vector_interrupt_unit_tb.sv
// Self-checking bench of the single-vector interrupt unit
`timescale 1ns/100ps
`default_nettype none
module single_vector_interrupt_unit_tb;
  import irq_unit_pkg::*;
  typedef struct packed {logic [9:0] en; logic [9:0] fl; logic [3:0] bm;} row_t;
  logic clk = 1'h0, resetn = 1'h0, read = 1'h0, write = 1'h0;
  logic [ADDR_W-1:0] address = '0;
  logic [DATA_W-1:0] writedata = '0, readdata, d;
  logic waitrequest, cpu_irq, wake, watchdog_clear, comparator_enable, irq, cpu_ack, cpu_return;
  logic [11:0] vector_addr, fetched_vector;
  logic [12:0] ev = 13'h0;
  logic [4:0] pin_lv = 5'h1f;
  logic sleep_mode = 1'h0, stop_mode = 1'h0, auto_en = 1'h0, busy;
  logic [3:0] fb;
  logic [3:0] pv [5] = '{4'h0, 4'h1, 4'h9, 4'h0, 4'h2};
  logic [9:0] zidx [11] = '{IDX_TIMER_EN, IDX_TIMER_FLAGS, IDX_EXT_EN, IDX_EXT_FLAGS,
    IDX_TOUCH_EN, IDX_TOUCH_FLAGS, IDX_BUS_EN, IDX_BUS_FLAGS, IDX_TRIGGER_SEL,
    IDX_PIN_DET_SEL, 10'h3ff};
  row_t rows [13];
  int err_count = 0, total_checks = 0, wd_seen = 0, ack_seen = 0;

  single_vector_interrupt_unit i_dut (.clk(clk), .resetn(resetn), .address(address),
    .read(read), .write(write), .byteenable(4'hf), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .tick_one(ev[0]), .timer_one_ovf(ev[1]),
    .timer_two_ovf(ev[2]), .tick_two(ev[3]), .converter_done(ev[4]),
    .timer_three_ovf(ev[5]), .touch_scan_done(ev[6]), .touch_overcharge(ev[7]),
    .touch_duty_ovf(ev[8]), .bus_event(ev[9]), .bus_start(ev[10]), .bus_stop(ev[11]),
    .bus_first_byte(ev[12]), .ext_a_primary_pin(pin_lv[0]), .ext_a_alternate_pin(pin_lv[1]),
    .ext_a_comparator(pin_lv[2]), .ext_b_primary_pin(pin_lv[3]),
    .ext_b_alternate_pin(pin_lv[4]), .cpu_ack(cpu_ack), .cpu_return(cpu_return),
    .sleep_mode(sleep_mode), .stop_mode(stop_mode), .cpu_irq(cpu_irq),
    .vector_addr(vector_addr), .wake(wake), .watchdog_clear(watchdog_clear),
    .comparator_enable(comparator_enable), .irq(irq));
  cpu_core_model i_cpu (.clk(clk), .resetn(resetn), .cpu_irq(cpu_irq),
    .vector_addr(vector_addr), .auto_en(auto_en), .service_cycles(8'h28),
    .cpu_ack(cpu_ack), .cpu_return(cpu_return), .fetched_vector(fetched_vector), .busy(busy));

  always #50 clk = ~clk;
  // Counted between edges so a check at the next edge already sees the count
  always @(negedge clk) begin
    if (watchdog_clear === 1'h1) wd_seen++;
    if (cpu_ack === 1'h1) ack_seen++;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [9:0] idx, input logic [3:0] v);
    @(posedge clk);
    address <= {idx, 2'h0};
    writedata <= {28'h0, v};
    write <= wr;
    read <= !wr;
    // Held until waitrequest is seen low at a rising edge
    for (int n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitrequest === 1'h0) break;
    end
    check("bus_answer", waitrequest, 1'h0);
    d = readdata;
    write <= 1'h0;
    read <= 1'h0;
  endtask : bus

  task automatic tick(input int k);
    @(posedge clk);
    ev <= 13'h1 << k;
    @(posedge clk);
    ev <= 13'h0;
    repeat (2) @(posedge clk);
  endtask : tick

  task automatic wait_model(input logic lvl);
    for (int n = 0; n < 300 && busy !== lvl; n++) @(posedge clk);
    check("model_busy", busy, lvl);
  endtask : wait_model

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  initial begin
    #2_000_000;
    err_count++;
    wrap_up();
  end

  initial begin
    rows = '{'{IDX_TIMER_EN, IDX_TIMER_FLAGS, 4'h1}, '{IDX_TIMER_EN, IDX_TIMER_FLAGS, 4'h2},
      '{IDX_TIMER_EN, IDX_TIMER_FLAGS, 4'h4}, '{IDX_TIMER_EN, IDX_TIMER_FLAGS, 4'h8},
      '{IDX_EXT_EN, IDX_EXT_FLAGS, 4'h4}, '{IDX_EXT_EN, IDX_EXT_FLAGS, 4'h8},
      '{IDX_TOUCH_EN, IDX_TOUCH_FLAGS, 4'h2}, '{IDX_TOUCH_EN, IDX_TOUCH_FLAGS, 4'h4},
      '{IDX_TOUCH_EN, IDX_TOUCH_FLAGS, 4'h8}, '{IDX_BUS_EN, IDX_BUS_FLAGS, 4'h1},
      '{IDX_BUS_EN, IDX_BUS_FLAGS, 4'h2}, '{IDX_BUS_EN, IDX_BUS_FLAGS, 4'h4},
      '{IDX_BUS_EN, IDX_BUS_FLAGS, 4'h8}};
    repeat (10) @(posedge clk);
    check("rst_wait", waitrequest, 1'h1);
    check("rst_vector", vector_addr, SERVICE_VECTOR);
    check("rst_outs", {cpu_irq, wake, watchdog_clear, irq}, 4'h0);
    resetn <= 1'h1;
    foreach (zidx[i]) begin
      bus(1'h0, zidx[i], 4'h0);
      check("reset_value", d, 32'h0);
    end
    bus(1'h1, 10'h3ff, 4'hf);
    bus(1'h0, 10'h3ff, 4'h0);
    check("unmapped", d, 32'h0);
    bus(1'h1, IDX_TOUCH_FLAGS, 4'hf);
    bus(1'h0, IDX_TOUCH_FLAGS, 4'h0);
    check("touch_bit0", d, 32'he);
    bus(1'h1, IDX_PIN_DET_SEL, 4'hf);
    bus(1'h0, IDX_PIN_DET_SEL, 4'h0);
    check("pin_det_bits", d, 32'hb);
    bus(1'h1, IDX_TOUCH_FLAGS, 4'h0);
    bus(1'h1, IDX_TIMER_FLAGS, 4'he);
    bus(1'h1, IDX_EXT_FLAGS, 4'he);
    bus(1'h0, IDX_TIMER_FLAGS, 4'h0);
    check("timer_w1", d, 32'h0);
    bus(1'h0, IDX_EXT_FLAGS, 4'h0);
    check("ext_w1", d, 32'h0);
    foreach (rows[k]) begin
      bus(1'h1, rows[k].en, 4'h0);
      tick(k);
      bus(1'h0, rows[k].fl, 4'h0);
      check("flag_set", d, {28'h0, rows[k].bm});
      check("irq_disabled", cpu_irq, 1'h0);
      bus(1'h1, rows[k].en, rows[k].bm);
      repeat (2) @(posedge clk);
      check("irq_enabled", cpu_irq, 1'h1);
      bus(1'h1, rows[k].fl, 4'h0);
      bus(1'h0, rows[k].fl, 4'h0);
      check("flag_clear", d, 32'h0);
      check("irq_cleared", cpu_irq, 1'h0);
      bus(1'h1, rows[k].en, 4'h0);
    end
    for (int p = 0; p < 5; p++) begin
      for (int c = 0; c < 4; c++) begin
        fb = (p < 3) ? 4'h1 : 4'h2;
        bus(1'h1, IDX_TRIGGER_SEL, (p < 3) ? {2'h0, c[1:0]} : {c[1:0], 2'h0});
        bus(1'h1, IDX_PIN_DET_SEL, pv[p]);
        bus(1'h1, IDX_EXT_FLAGS, 4'h0);
        check("cmp_enable", comparator_enable, p == 2);
        @(posedge clk);
        pin_lv[p] <= 1'h0;
        repeat (8) @(posedge clk);
        bus(1'h0, IDX_EXT_FLAGS, 4'h0);
        check("after_fall", d[3:0] & fb, (c != 2) ? fb : 4'h0);
        bus(1'h1, IDX_EXT_FLAGS, 4'h0);
        bus(1'h0, IDX_EXT_FLAGS, 4'h0);
        check("held_low", d[3:0] & fb, (c == 0) ? fb : 4'h0);
        @(posedge clk);
        pin_lv[p] <= 1'h1;
        repeat (8) @(posedge clk);
        bus(1'h0, IDX_EXT_FLAGS, 4'h0);
        check("after_rise", d[3:0] & fb, (c != 1) ? fb : 4'h0);
        bus(1'h1, IDX_EXT_FLAGS, 4'h0);
      end
    end
    bus(1'h1, IDX_TIMER_EN, 4'h1);
    tick(0);
    @(posedge clk);
    sleep_mode <= 1'h1;
    repeat (3) @(posedge clk);
    check("sleep_wake", wake, 1'h1);
    sleep_mode <= 1'h0;
    stop_mode <= 1'h1;
    repeat (3) @(posedge clk);
    check("stop_no_wake", wake, 1'h0);
    bus(1'h1, IDX_EXT_EN, 4'h1);
    bus(1'h1, IDX_TRIGGER_SEL, {2'h0, TRIG_FALLING});
    bus(1'h1, IDX_PIN_DET_SEL, 4'h0);
    pin_lv[0] <= 1'h0;
    repeat (8) @(posedge clk);
    check("stop_ext_wake", wake, 1'h1);
    stop_mode <= 1'h0;
    pin_lv[0] <= 1'h1;
    repeat (8) @(posedge clk);
    bus(1'h1, IDX_EXT_EN, 4'h0);
    bus(1'h1, IDX_EXT_FLAGS, 4'h0);
    bus(1'h1, IDX_TIMER_FLAGS, 4'h0);
    bus(1'h1, IDX_WATCHDOG_CLEAR, 4'h0);
    repeat (4) @(posedge clk);
    check("wdog_unarmed", wd_seen, 0);
    bus(1'h1, IDX_TIMER_FLAGS, WDOG_ARM_VALUE);
    bus(1'h1, IDX_WATCHDOG_CLEAR, 4'h0);
    repeat (4) @(posedge clk);
    check("wdog_pulse", wd_seen, 1);
    bus(1'h1, IDX_TIMER_FLAGS, WDOG_ARM_VALUE);
    bus(1'h1, IDX_TIMER_FLAGS, 4'h7);
    bus(1'h1, IDX_WATCHDOG_CLEAR, 4'h0);
    repeat (4) @(posedge clk);
    check("wdog_disarm", wd_seen, 1);
    bus(1'h0, IDX_EVENT_STATUS, 4'h0);
    check("wdog_event", d[1], 1'h1);
    check("irq_masked", irq, 1'h0);
    bus(1'h1, IDX_EVENT_STATUS, 4'h7);
    bus(1'h1, IDX_EVENT_MASK, 4'h1);
    bus(1'h1, IDX_TIMER_EN, 4'h3);
    auto_en <= 1'h1;
    tick(1);
    wait_model(1'h1);
    check("irq_event", irq, 1'h1);
    tick(0);
    check("held_in_service", cpu_irq, 1'h0);
    bus(1'h0, IDX_SERVICE_STATE, 4'h0);
    check("in_service", d[0], 1'h1);
    bus(1'h0, IDX_TIMER_FLAGS, 4'h0);
    check("isr_flags", d, 32'h3);
    bus(1'h1, IDX_TIMER_FLAGS, 4'h1);
    wait_model(1'h0);
    wait_model(1'h1);
    check("second_entry", ack_seen, 2);
    bus(1'h1, IDX_TIMER_FLAGS, 4'h0);
    wait_model(1'h0);
    repeat (4) @(posedge clk);
    check("no_third_entry", ack_seen, 2);
    check("vector", fetched_vector, SERVICE_VECTOR);
    bus(1'h1, IDX_EVENT_STATUS, 4'h7);
    repeat (2) @(posedge clk);
    check("irq_cleared", irq, 1'h0);
    wrap_up();
  end
endmodule : single_vector_interrupt_unit_tb
`default_nettype wire
